//--- hdl/srqps_top.v
// Service request, serial poll status byte and program sequencer
`timescale 1ns/1ns
`include "srqps_regs.vh"
module srqps_top #(
	parameter ADDR_W = 7,
	parameter DWELL_W = 16,
	parameter PORT_W = 4,
	parameter TICK_CYC = `SRQPS_TICK_CYC
) (
	clk,
	reset,
	dev_clear,
	mask_wr,
	mask_val,
	mode_wr,
	mode_val,
	eot_wr,
	eot_val,
	poll_rd,
	status_byte,
	srq,
	illegal_command_error,
	illegal_option_error,
	not_remote_error,
	over_limit,
	port_in,
	start_trig,
	stop_trig,
	step_trig,
	dwell_val,
	mem_last,
	whole_buffer_fmt,
	out_last_byte,
	eoi,
	running,
	mem_addr,
	prog_mode,
	end_marker
);
	input wire clk;
	input wire reset;
	input wire dev_clear;
	input wire mask_wr;
	input wire [7:0] mask_val;
	input wire mode_wr;
	input wire [1:0] mode_val;
	input wire eot_wr;
	input wire eot_val;
	input wire poll_rd;
	output reg [7:0] status_byte;
	output wire srq;
	input wire illegal_command_error;
	input wire illegal_option_error;
	input wire not_remote_error;
	input wire over_limit;
	input wire [PORT_W-1:0] port_in;
	input wire start_trig;
	input wire stop_trig;
	input wire step_trig;
	input wire [DWELL_W-1:0] dwell_val;
	input wire [ADDR_W-1:0] mem_last;
	input wire whole_buffer_fmt;
	input wire out_last_byte;
	output wire eoi;
	output reg running;
	output reg [ADDR_W-1:0] mem_addr;
	output reg [1:0] prog_mode;
	output reg end_marker;

	// ***************************************
	// Settings
	// ***************************************
	reg [`SRQPS_MASK_W-1:0] mask_r;
	wire clr = reset | dev_clear;
	always @(posedge clk) begin
		if (clr) begin
			mask_r <= `SRQPS_MASK_RST;
			prog_mode <= `SRQPS_MODE_RST;
			end_marker <= `SRQPS_END_MARKER_ON;
		end else begin
			if (mask_wr && mask_val <= `SRQPS_MASK_MAX)
				mask_r <= mask_val[`SRQPS_MASK_W-1:0];
			if (mode_wr && mode_val <= `SRQPS_STEPPED_PROGRAM)
				prog_mode <= mode_val;
			if (eot_wr)
				end_marker <= eot_val;
		end
	end

	// ***************************************
	// End marker
	// ***************************************
	// Whole-buffer formats: out_last_byte is driven only for the final
	// byte of the full memory dump, never per location
	assign eoi = (end_marker == `SRQPS_END_MARKER_ON) & out_last_byte;

	// ***************************************
	// Port change detect
	// ***************************************
	wire [PORT_W-1:0] port_s;
	reg [PORT_W-1:0] port_d_r;
	srqps_sync #(.W(PORT_W)) u_sync (
		.clk(clk),
		.reset(reset),
		.d(port_in),
		.q(port_s)
	);
	always @(posedge clk) begin
		if (reset)
			port_d_r <= {PORT_W{1'b0}};
		else
			port_d_r <= port_s;
	end
	wire port_chg = |(port_s ^ port_d_r);

	// ***************************************
	// Sequencer
	// ***************************************
	wire tick;
	reg [DWELL_W-1:0] dwell_cnt_r;
	reg ev_eob;
	reg ev_dwell;
	srqps_tick #(.DIV(TICK_CYC)) u_tick (
		.clk(clk),
		.reset(reset),
		.tick(tick)
	);
	wire at_end = (dwell_val == {DWELL_W{1'b0}}) || (mem_addr == mem_last);
	wire stepped = (prog_mode == `SRQPS_STEPPED_PROGRAM);
	always @(posedge clk) begin
		ev_eob <= 1'b0;
		ev_dwell <= 1'b0;
		if (clr) begin
			running <= 1'b0;
			mem_addr <= {ADDR_W{1'b0}};
			dwell_cnt_r <= {DWELL_W{1'b0}};
		end else if (stepped) begin
			running <= 1'b0;
			if (step_trig) begin
				// A zero-dwell or last location sends the next trigger home
				if (at_end) begin
					mem_addr <= {ADDR_W{1'b0}};
				end else begin
					mem_addr <= mem_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
				end
			end
		end else if (!running) begin
			if (start_trig) begin
				running <= 1'b1;
				dwell_cnt_r <= {DWELL_W{1'b0}};
			end
		end else if (stop_trig) begin
			running <= 1'b0;
		end else if (at_end) begin
			ev_eob <= 1'b1;
			if (prog_mode == `SRQPS_CONTINUOUS_PROGRAM) begin
				mem_addr <= {ADDR_W{1'b0}};
			end else begin
				running <= 1'b0;
			end
			dwell_cnt_r <= {DWELL_W{1'b0}};
		end else if (tick) begin
			if (dwell_cnt_r + {{(DWELL_W-1){1'b0}}, 1'b1} >= dwell_val) begin
				ev_dwell <= 1'b1;
				dwell_cnt_r <= {DWELL_W{1'b0}};
				mem_addr <= mem_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
			end else begin
				dwell_cnt_r <= dwell_cnt_r + {{(DWELL_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// ***************************************
	// Status byte and request
	// ***************************************
	wire any_err = illegal_command_error | illegal_option_error | not_remote_error;
	wire err_en = mask_r[`SRQPS_M_ERR] & any_err;
	wire [3:0] data_ev = {port_chg & mask_r[`SRQPS_M_PORT],
		ev_dwell & mask_r[`SRQPS_M_DWELL],
		ev_eob & mask_r[`SRQPS_M_EOB],
		over_limit & mask_r[`SRQPS_M_LIMIT]};
	reg [2:0] err_lat_r;
	reg [3:0] data_lat_r;
	always @(posedge clk) begin
		if (clr) begin
			err_lat_r <= 3'h0;
			data_lat_r <= 4'h0;
		end else begin
			// A new event in the poll cycle is kept
			err_lat_r <= (poll_rd ? 3'h0 : err_lat_r) | ({3{err_en}} &
				{not_remote_error, illegal_option_error, illegal_command_error});
			data_lat_r <= (poll_rd ? 4'h0 : data_lat_r) | data_ev;
		end
	end
	wire is_err = |err_lat_r;
	assign srq = is_err | (|data_lat_r);
	always @(posedge clk) begin
		if (reset)
			status_byte <= 8'h00;
		else begin
			status_byte[7] <= 1'b0;
			status_byte[`SRQPS_SB_RQS] <= srq;
			status_byte[`SRQPS_SB_ERRSEL] <= is_err;
			status_byte[4] <= 1'b0;
			if (is_err)
				status_byte[3:0] <= {1'b0, err_lat_r};
			else
				status_byte[3:0] <= data_lat_r;
		end
	end
endmodule

//--- pkg/srqps_regs.vh
// Constants for the service-request and program sequencer block
// Overview of operation
// - Whole-buffer formats assert end marker only on final byte of whole transfer
// - Power-up, device clear or selected clear empties the request mask
// - Mask written by command with value 0 to 31; zero disables requests
// - Weight one: illegal command, illegal option, or programmed while not remote
// - Weight two: output beyond its compliance limit
// - Weight four: end of program memory reached while running
// - Weight eight: dwell time of current location expired while running
// - Weight sixteen: any change on digital port input lines
// - Weights add; any enabled condition raises a request
// - Status bit 6 set when this device requests service
// - Status bit 5 selects error or data meaning of bits 0 to 3
// - Error view: bit0 illegal command, bit1 illegal option, bit2 not remote
// - Data view: bit0 limit, bit1 end buffer, bit2 end dwell, bit3 port
// - Request held until serial poll reads status byte, which releases it
// - Single mode steps through once and stops at zero dwell
// - Continuous mode wraps at zero dwell until a stop trigger
// - Step mode advances one per trigger, wraps after zero dwell location
// - Mode values 0,1,2 are single, continuous, step; step after reset or clear
// - End marker setting 0 marks last byte, 1 suppresses; 0 after reset
`ifndef SRQPS_REGS_VH
`define SRQPS_REGS_VH
`define SRQPS_MASK_W 5
`define SRQPS_MASK_MAX 8'h1f
`define SRQPS_MASK_RST 5'h00
`define SRQPS_M_ERR 0
`define SRQPS_M_LIMIT 1
`define SRQPS_M_EOB 2
`define SRQPS_M_DWELL 3
`define SRQPS_M_PORT 4
`define SRQPS_SB_RQS 6
`define SRQPS_SB_ERRSEL 5
`define SRQPS_SINGLE_PASS_PROGRAM 2'h0
`define SRQPS_CONTINUOUS_PROGRAM 2'h1
`define SRQPS_STEPPED_PROGRAM 2'h2
`define SRQPS_MODE_RST 2'h2
`define SRQPS_END_MARKER_ON 1'b0
`define SRQPS_END_MARKER_OFF 1'b1
`define SRQPS_TICK_NS 1000
`define SRQPS_CLK_NS 20
`define SRQPS_TICK_CYC (`SRQPS_TICK_NS / `SRQPS_CLK_NS)
`endif

//--- hdl/srqps_tick.v
// Dwell time base divider producing one-cycle enable pulses
`timescale 1ns/1ns
module srqps_tick #(
	parameter DIV = 50
) (
	clk,
	reset,
	tick
);
	input wire clk;
	input wire reset;
	output reg tick;
	reg [15:0] cnt_r;
	always @(posedge clk) begin
		if (reset) begin
			cnt_r <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt_r == DIV[15:0] - 16'h0001) begin
			cnt_r <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule

//--- hdl/srqps_sync.v
// Two flip-flop synchroniser for pin inputs, one per bit
`timescale 1ns/1ns
module srqps_sync #(
	parameter W = 1
) (
	clk,
	reset,
	d,
	q
);
	input wire clk;
	input wire reset;
	input wire [W-1:0] d;
	output reg [W-1:0] q;
	reg [W-1:0] meta_r;
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge clk) begin
				if (reset) begin
					meta_r[i] <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					meta_r[i] <= d[i];
					q[i] <= meta_r[i];
				end
			end
		end
	endgenerate
endmodule

//--- verification/srqps_checker.sv
// Checker of request, status byte, mode and end marker behaviour
`timescale 1ns/1ns
module srqps_checker (
	input wire clk,
	input wire reset,
	input wire dev_clear,
	input wire mode_wr,
	input wire [1:0] mode_val,
	input wire eot_wr,
	input wire eot_val,
	input wire poll_rd,
	input wire [7:0] status_byte,
	input wire srq,
	input wire out_last_byte,
	input wire eoi,
	input wire [1:0] prog_mode,
	input wire end_marker
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_eoi; eoi == (!end_marker && out_last_byte); endproperty
	a_eoi: assert property (p_eoi) else $error("eoi");
	property p_clr; dev_clear |=> !srq && prog_mode == 2'h2 && !end_marker; endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_hold; srq && !poll_rd && !dev_clear |=> srq; endproperty
	a_hold: assert property (p_hold) else $error("srq dropped");
	property p_rqs; !$past(dev_clear) |-> status_byte[6] == $past(srq); endproperty
	a_rqs: assert property (p_rqs) else $error("bit 6");
	property p_err; status_byte[5] |-> !status_byte[3]; endproperty
	a_err: assert property (p_err) else $error("bit 3");
	property p_lat; status_byte[3:0] != 4'h0 |-> status_byte[6]; endproperty
	a_lat: assert property (p_lat) else $error("latch");
	property p_mode;
		mode_wr && mode_val != 2'h3 && !dev_clear |=> prog_mode == $past(mode_val);
	endproperty
	a_mode: assert property (p_mode) else $error("mode");
	property p_mode_ref; mode_wr && mode_val == 2'h3 && !dev_clear |=> $stable(prog_mode); endproperty
	a_mode_ref: assert property (p_mode_ref) else $error("mode 3 taken");
	property p_mark; eot_wr && !dev_clear |=> end_marker == $past(eot_val); endproperty
	a_mark: assert property (p_mark) else $error("marker");
endmodule
bind srqps_top srqps_checker srqps_checker_inst (.*);

//--- verification/srqps_ctrl_model.sv
// Bus controller model that serial polls once per request
`timescale 1ns/1ns
module srqps_ctrl_model (
	input wire clk,
	input wire srq,
	input wire [7:0] status_byte,
	input wire en,
	input wire [3:0] dly,
	output reg poll_rd = 1'b0,
	output reg [7:0] sb_got = 8'h00
);
	always begin
		@(posedge clk);
		#1;
		if (en && srq) begin
			// Status byte trails the request by one edge
			repeat (dly + 1) @(posedge clk);
			#1 sb_got = status_byte;
			poll_rd = 1'b1;
			@(posedge clk);
			#1 poll_rd = 1'b0;
		end
	end
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the request and program sequencer block
`timescale 1ns/1ns
module tb_top;
	reg clk = 1'b0, reset = 1'b1, clr = 1'b0, en = 1'b0, obl = 1'b0;
	reg [2:0] wr = 3'h0, tg = 3'h0;
	reg [3:0] ev = 4'h0, pin = 4'h0, dly = 4'h0;
	reg [7:0] v = 8'h00, e, q[$];
	reg [4:0] m;
	reg [31:0] rs = 32'h6eb2d144;
	integer err_count = 0, n_checks = 0, n, c, w, k;
	wire srq, prd, run, eo;
	wire [7:0] sb, sg;
	wire [6:0] ma;
	wire [1:0] pm;
	srqps_top #(.TICK_CYC(2)) srqps_top_inst (.clk(clk), .reset(reset), .dev_clear(clr),
		.mask_wr(wr[0]), .mask_val(v), .mode_wr(wr[1]), .mode_val(v[1:0]), .eot_wr(wr[2]),
		.eot_val(v[0]), .poll_rd(prd), .status_byte(sb), .srq(srq),
		.illegal_command_error(ev[0]), .illegal_option_error(ev[1]),
		.not_remote_error(ev[2]), .over_limit(ev[3]), .port_in(pin), .start_trig(tg[0]),
		.stop_trig(tg[1]), .step_trig(tg[2]), .dwell_val({15'h0, ma != 7'h2}),
		.mem_last(7'h7), .whole_buffer_fmt(obl), .out_last_byte(obl), .eoi(eo),
		.running(run), .mem_addr(ma), .prog_mode(pm), .end_marker());
	srqps_ctrl_model srqps_ctrl_model_inst (.clk(clk), .srq(srq), .status_byte(sb),
		.en(en), .dly(dly), .poll_rd(prd), .sb_got(sg));
	always #10 clk = ~clk;
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	task cy(input integer i);
		repeat (i) @(posedge clk);
		#1;
	endtask
	task ck(input string nm, input [7:0] seen, input [7:0] want);
		n_checks = n_checks + 1;
		if (seen !== want) begin
			err_count = err_count + 1;
			$display("unexpected %s: expected %h seen %h", nm, want, seen);
		end
	endtask
	task close_out;
		if (err_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// One-cycle strobe of write select, value, causes, triggers and clear, then one idle edge
	task st(input [2:0] s, input [7:0] d, input [3:0] x, input [2:0] t, input c0);
		{wr, v, ev, tg, clr} = {s, d, x, t, c0};
		cy(1);
		{wr, ev, tg, clr} = 11'h0;
		cy(1);
	endtask
	// Note the byte, then let the controller poll once within a bounded wait
	task pl(input [7:0] want);
		q.push_back(want);
		en = 1'b1;
		for (k = 0; k < 300 && q.size() > 0; k = k + 1)
			cy(1);
		en = 1'b0;
		ck("polls", 8'(q.size()), 8'h00);
	endtask
	always @(posedge clk)
		if (prd && q.size() > 0)
			ck("status_byte", sg, q.pop_front());
	initial begin
		#400000;
		err_count = err_count + 1;
		close_out;
	end
	initial begin
		cy(12);
		reset = 1'b0;
		ck("prog_mode", pm, 8'h02);
		ck("status_byte", sb, 8'h00);
		// Each error, limit and port cause under a random mask; later passes force its weight on
		for (n = 0; n < 15; n = n + 1) begin
			rs = xs(rs);
			c = n % 5;
			w = (c < 3) ? 0 : ((c == 3) ? 1 : 4);
			m = rs[4:0] | ((n > 9) ? 5'h1 << w : 5'h0);
			dly = rs[11:8];
			e = (c < 3) ? 8'h60 | (8'h1 << c) : 8'h40 | (8'h1 << (c * 3 - 9));
			st(3'h1, {3'h0, m}, 4'h0, 3'h0, 1'b0);
			if (c == 4)
				pin = pin ^ (rs[23:20] | 4'h1);
			else
				st(3'h0, 8'h00, 4'h1 << c, 3'h0, 1'b0);
			if (m[w])
				pl(e);
			else begin
				cy(6);
				ck("srq", srq, 8'h00);
			end
		end
		st(3'h1, 8'h03, 4'h0, 3'h0, 1'b0);
		st(3'h1, 8'h20, 4'h9, 3'h0, 1'b0);
		pl(8'h61);
		st(3'h2, 8'h00, 4'h0, 3'h0, 1'b0);
		st(3'h1, 8'h04, 4'h0, 3'h1, 1'b0);
		pl(8'h42);
		ck("running", run, 8'h00);
		st(3'h2, 8'h01, 4'h0, 3'h0, 1'b0);
		st(3'h1, 8'h08, 4'h0, 3'h1, 1'b0);
		pl(8'h44);
		ck("running", run, 8'h01);
		st(3'h1, 8'h1f, 4'h0, 3'h2, 1'b0);
		ck("running", run, 8'h00);
		st(3'h0, 8'h00, 4'h0, 3'h0, 1'b1);
		ck("srq", srq, 8'h00);
		ck("prog_mode", pm, 8'h02);
		st(3'h0, 8'h00, 4'hf, 3'h0, 1'b0);
		ck("srq", srq, 8'h00);
		st(3'h2, 8'h03, 4'h0, 3'h0, 1'b0);
		ck("prog_mode", pm, 8'h02);
		for (n = 1; n < 4; n = n + 1) begin
			st(3'h0, 8'h00, 4'h0, 3'h4, 1'b0);
			ck("mem_addr", {1'b0, ma}, 8'(n % 3));
		end
		obl = 1'b1;
		cy(1);
		ck("eoi", eo, 8'h01);
		st(3'h4, 8'h01, 4'h0, 3'h0, 1'b0);
		ck("eoi", eo, 8'h00);
		st(3'h4, 8'h00, 4'h0, 3'h0, 1'b0);
		ck("eoi", eo, 8'h01);
		close_out;
	end
endmodule
